// ### verilog/tcc_consts.vh
// Constants for the timer channel capture/compare block.
// Assumes byte addresses on a 32-bit Avalon-MM register bus.
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TCC_OFS_STATUS_CONTROL 8'h18
`define TCC_OFS_VALUE_HIGH     8'h1c
`define TCC_OFS_VALUE_LOW      8'h20

// ----------------------------------------
// Status/control fields and reset values
// ----------------------------------------
`define TCC_BIT_EVENT_FLAG     7
`define TCC_BIT_INT_ENABLE     6
`define TCC_BIT_MODE_B         5
`define TCC_BIT_MODE_A         4
`define TCC_ELS_HI             3
`define TCC_ELS_LO             2
`define TCC_SC_RESET           8'h00
`define TCC_VALUE_RESET        16'h0000

// ----------------------------------------
// Channel modes and edge/level codes
// ----------------------------------------
`define TCC_MODE_CAPTURE       2'h0
`define TCC_MODE_COMPARE       2'h1
`define TCC_MODE_EDGE_PWM      2'h2
`define TCC_MODE_CENTER_PWM    2'h3
`define TCC_ELS_OFF            2'h0
`define TCC_ELS_01             2'h1
`define TCC_ELS_10             2'h2
`define TCC_ELS_11             2'h3

`endif

// ### verilog/tcc_channel.v
// One capture/compare channel of a 16-bit timer/PWM module.
// Assumes main counter, overflow and count direction come from
// logic on i_clk; the channel pin input is asynchronous.
//
// Overview of operation
// - Value pair holds capture or compare value
// - Reset clears both value bytes
// - Capture mode: byte read freezes both bytes
// - Status/control write releases read freeze
// - Compare/PWM: both bytes buffered, moved together
// - Status/control write drops half-written pair
// - Capture: selected pin edge sets event flag
// - Compare/edge PWM: counter match sets flag
// - Center PWM: every match sets flag
// - Interrupt request when flag and enable set
// - Clear flag: read while set, write zero
// - Event between read and write cancels clear
// - Writing one to flag ignored; reset clears
// - Interrupt enable bit read/write, reset zero
// - Mode B selects edge-aligned PWM
// - Mode A picks capture or compare
// - Edge/level field sets edge, level, polarity
// - Code 00 releases pin, pinless timer
// - Capture codes: rising, falling, either edge
// - Compare codes: none, toggle, low, high
// - PWM: 10 high-true, X1 low-true pulses
// - Center-aligned select overrides channel mode
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_channel
(
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire [7:0]  i_avs_address,
   input  wire        i_avs_read,
   input  wire        i_avs_write,
   input  wire [31:0] i_avs_writedata,
   input  wire [3:0]  i_avs_byteenable,
   output wire [31:0] o_avs_readdata,
   output wire        o_avs_waitrequest,
   input  wire [15:0] i_main_counter,
   input  wire        i_count_tick,
   input  wire        i_counter_overflow,
   input  wire        i_count_down,
   input  wire        i_center_aligned_select,
   input  wire        i_pin,
   output wire        o_pin_out,
   output wire        o_pin_oe_n,
   output wire        o_irq
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg  [15:0] value_reg;
   reg  [15:0] hold_reg;
   reg         frozen_reg;
   reg         frozen_high_reg;
   reg  [7:0]  wbuf_high_reg;
   reg  [7:0]  wbuf_low_reg;
   reg         wbuf_high_ok_reg;
   reg         wbuf_low_ok_reg;
   reg         flag_reg;
   reg         armed_reg;
   reg         int_enable_reg;
   reg         mode_b_reg;
   reg         mode_a_reg;
   reg  [1:0]  els_reg;
   reg         sync1_reg;
   reg         sync2_reg;
   reg         pin_prev_reg;
   reg         pin_out_reg;
   reg         pin_oe_n_reg;
   reg         irq_reg;
   reg         wait_reg;
   reg  [31:0] rdata_reg;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire        req      = i_avs_read | i_avs_write;
   // Writes land as waitrequest ends; read side effects go with the data load
   wire        done     = req & ~wait_reg;
   wire        rd_start = i_avs_read & wait_reg;
   wire        wr_done  = done & i_avs_write & i_avs_byteenable[0];
   wire        sel_sc   = (i_avs_address == `TCC_OFS_STATUS_CONTROL);
   wire        sel_hi   = (i_avs_address == `TCC_OFS_VALUE_HIGH);
   wire        sel_lo   = (i_avs_address == `TCC_OFS_VALUE_LOW);
   wire [7:0]  wbyte    = i_avs_writedata[7:0];

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   reg  [1:0]  mode;
   always @*
   begin
      if (i_center_aligned_select)
         mode = `TCC_MODE_CENTER_PWM;
      // Mode B alone means edge PWM
      else if (mode_b_reg)
         mode = `TCC_MODE_EDGE_PWM;
      // Mode A picks compare over capture
      else if (mode_a_reg)
         mode = `TCC_MODE_COMPARE;
      else
         mode = `TCC_MODE_CAPTURE;
   end
   wire        capture_mode = (mode == `TCC_MODE_CAPTURE);

   // ----------------------------------------
   // Channel events
   // ----------------------------------------
   wire        rise  = sync2_reg & ~pin_prev_reg;
   wire        fall  = ~sync2_reg & pin_prev_reg;
   reg         edge_hit;
   always @*
   begin
      case (els_reg)
         `TCC_ELS_01: edge_hit = rise;
         `TCC_ELS_10: edge_hit = fall;
         `TCC_ELS_11: edge_hit = rise | fall;
         default:     edge_hit = 1'b0;
      endcase
   end
   // Match counted once per new counter value, not per bus cycle
   wire        match   = i_count_tick & (i_main_counter == value_reg);
   // Pin edge is the capture event
   wire        cap_evt = capture_mode & edge_hit;
   // Any match in the other modes
   wire        cmp_evt = ~capture_mode & match;
   wire        event_now = cap_evt | cmp_evt;

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sync1_reg    <= 1'b0;
         sync2_reg    <= 1'b0;
         pin_prev_reg <= 1'b0;
      end
      else
      begin
         sync1_reg    <= i_pin;
         sync2_reg    <= sync1_reg;
         pin_prev_reg <= sync2_reg;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   reg  [7:0]  rbyte;
   always @*
   begin
      rbyte = 8'h00;
      if (sel_sc)
         rbyte = {flag_reg, int_enable_reg, mode_b_reg, mode_a_reg, els_reg, 2'h0};
      // Frozen bytes served from the hold buffer
      else if (sel_hi)
         rbyte = (capture_mode & frozen_reg) ? hold_reg[15:8] : value_reg[15:8];
      else if (sel_lo)
         rbyte = (capture_mode & frozen_reg) ? hold_reg[7:0] : value_reg[7:0];
   end

   // ----------------------------------------
   // Avalon slave handshake
   // ----------------------------------------
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h00000000;
      end
      else
      begin
         // One wait state per access; unmapped reads return zero
         wait_reg <= ~(req & wait_reg);
         if (req & wait_reg)
            rdata_reg <= {24'h000000, rbyte};
      end
   end

   // ----------------------------------------
   // Status/control register and event flag
   // ----------------------------------------
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         // Flag and enable clear on reset
         flag_reg       <= 1'b0;
         armed_reg      <= 1'b0;
         int_enable_reg <= 1'b0;
         mode_b_reg     <= 1'b0;
         mode_a_reg     <= 1'b0;
         els_reg        <= `TCC_ELS_OFF;
      end
      else
      begin
         if (wr_done & sel_sc)
         begin
            int_enable_reg <= wbyte[`TCC_BIT_INT_ENABLE];
            mode_b_reg     <= wbyte[`TCC_BIT_MODE_B];
            mode_a_reg     <= wbyte[`TCC_BIT_MODE_A];
            els_reg        <= wbyte[`TCC_ELS_HI:`TCC_ELS_LO];
         end
         // New event sets flag and cancels clear
         if (event_now)
         begin
            flag_reg  <= 1'b1;
            armed_reg <= 1'b0;
         end
         // Only a zero after arming clears
         else if (wr_done & sel_sc)
         begin
            if (armed_reg & ~wbyte[`TCC_BIT_EVENT_FLAG])
               flag_reg <= 1'b0;
            armed_reg <= 1'b0;
         end
         // Armed by the read that returns it set
         else if (rd_start & sel_sc & flag_reg)
            armed_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // Value register and byte buffers
   // ----------------------------------------
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         value_reg        <= `TCC_VALUE_RESET;
         hold_reg         <= `TCC_VALUE_RESET;
         frozen_reg       <= 1'b0;
         frozen_high_reg  <= 1'b0;
         wbuf_high_reg    <= 8'h00;
         wbuf_low_reg     <= 8'h00;
         wbuf_high_ok_reg <= 1'b0;
         wbuf_low_ok_reg  <= 1'b0;
      end
      else
      begin
         if (cap_evt)
            value_reg <= i_main_counter;
         // First byte read freezes, other byte releases
         if (rd_start & (sel_hi | sel_lo) & capture_mode)
         begin
            if (~frozen_reg)
            begin
               frozen_reg      <= 1'b1;
               frozen_high_reg <= sel_hi;
               hold_reg        <= value_reg;
            end
            else if (frozen_high_reg != sel_hi)
               frozen_reg <= 1'b0;
         end
         if (wr_done & sel_sc)
         begin
            frozen_reg       <= 1'b0;
            wbuf_high_ok_reg <= 1'b0;
            wbuf_low_ok_reg  <= 1'b0;
         end
         else if (wr_done & (sel_hi | sel_lo))
         begin
            if (capture_mode)
            begin
               // Capture mode writes go straight in
               if (sel_hi)
                  value_reg[15:8] <= wbyte;
               else
                  value_reg[7:0] <= wbyte;
            end
            // Pair moves as one 16-bit value
            else if ((sel_hi & wbuf_low_ok_reg) | (sel_lo & wbuf_high_ok_reg))
            begin
               value_reg        <= sel_hi ? {wbyte, wbuf_low_reg} : {wbuf_high_reg, wbyte};
               wbuf_low_ok_reg  <= 1'b0;
               wbuf_high_ok_reg <= 1'b0;
            end
            else if (sel_hi)
            begin
               wbuf_high_reg    <= wbyte;
               wbuf_high_ok_reg <= 1'b1;
            end
            else
            begin
               wbuf_low_reg    <= wbyte;
               wbuf_low_ok_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Pin output
   // ----------------------------------------
   reg         pin_next;
   always @*
   begin
      pin_next = pin_out_reg;
      case (mode)
         `TCC_MODE_COMPARE:
         begin
            // Match toggles, clears or sets the pin
            if (match)
            begin
               case (els_reg)
                  `TCC_ELS_01: pin_next = ~pin_out_reg;
                  `TCC_ELS_10: pin_next = 1'b0;
                  `TCC_ELS_11: pin_next = 1'b1;
                  default:     pin_next = pin_out_reg;
               endcase
            end
         end
         `TCC_MODE_EDGE_PWM:
         begin
            if (match)
               pin_next = els_reg[0];
            else if (i_counter_overflow)
               pin_next = ~els_reg[0];
         end
         `TCC_MODE_CENTER_PWM:
         begin
            // Compare-up ends pulse, compare-down starts it
            if (match)
               pin_next = els_reg[0] ^ i_count_down;
         end
         default: pin_next = pin_out_reg;
      endcase
   end
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pin_out_reg  <= 1'b0;
         pin_oe_n_reg <= 1'b1;
         irq_reg      <= 1'b0;
      end
      else
      begin
         pin_out_reg  <= pin_next;
         // Code 00 or capture leaves the pin undriven
         pin_oe_n_reg <= (els_reg == `TCC_ELS_OFF) | capture_mode;
         irq_reg      <= flag_reg & int_enable_reg;
      end
   end

   assign o_avs_readdata    = rdata_reg;
   assign o_avs_waitrequest = wait_reg;
   assign o_pin_out         = pin_out_reg;
   assign o_pin_oe_n        = pin_oe_n_reg;
   assign o_irq             = irq_reg;
endmodule // tcc_channel

// ### bench/tcc_channel_assertions.sv
// Checker for the tcc_channel bus, interrupt and pin ports.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_channel_assertions
(
   input wire        i_clk,
   input wire        i_rst,
   input wire [7:0]  i_avs_address,
   input wire        i_avs_read,
   input wire        i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0]  i_avs_byteenable,
   input wire [31:0] o_avs_readdata,
   input wire        o_avs_waitrequest,
   input wire        i_count_tick,
   input wire        i_counter_overflow,
   input wire        o_pin_out,
   input wire        o_pin_oe_n,
   input wire        o_irq
);
   // ----------------
   // Helpers
   // ----------------
   wire rd_done = i_avs_read && !o_avs_waitrequest;
   wire at_sc   = i_avs_address == `TCC_OFS_STATUS_CONTROL;
   wire mapped  = at_sc || i_avs_address == `TCC_OFS_VALUE_HIGH ||
                  i_avs_address == `TCC_OFS_VALUE_LOW;
   wire sc_wr   = i_avs_write && !o_avs_waitrequest && at_sc && i_avs_byteenable[0];

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // ----------------
   // Properties
   // ----------------
   a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("waitrequest not low one cycle after request");
   a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_wait_idle: assert property (!$past(i_avs_read) && !$past(i_avs_write)
      |-> o_avs_waitrequest) else $error("waitrequest low without request");
   a_irq_flag_enable: assert property (rd_done && at_sc
      |-> o_irq == (o_avs_readdata[7] & o_avs_readdata[6])) else $error("irq mismatch");
   a_sc_low_zero: assert property (rd_done && at_sc |-> o_avs_readdata[1:0] == 2'h0)
      else $error("status bits 1:0 not zero");
   a_read_upper: assert property (rd_done |-> o_avs_readdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_unmapped_zero: assert property (rd_done && !mapped |-> o_avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_pin_released: assert property (sc_wr && i_avs_writedata[3:2] == 2'h0
      |-> ##2 o_pin_oe_n) else $error("pin still driven with code 00");
   // Pin moves only on a counter event or a control write
   a_pin_cause: assert property ($changed(o_pin_out) |-> $past(i_count_tick) ||
      $past(i_counter_overflow) || $past(sc_wr) || $past(sc_wr, 2))
      else $error("pin changed without cause");
endmodule // tcc_channel_assertions

bind tcc_channel tcc_channel_assertions i_tcc_channel_assertions
(
   .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_count_tick(i_count_tick), .i_counter_overflow(i_counter_overflow),
   .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n), .o_irq(o_irq)
);

// ### bench/tcc_channel_test.sv
// Self-checking bench for tcc_channel over its Avalon-MM port.
// Assumes the bench drives counter, tick and pin in place of the timer.
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_channel_test;
   localparam logic [7:0] sc_a = `TCC_OFS_STATUS_CONTROL;
   localparam logic [7:0] vh_a = `TCC_OFS_VALUE_HIGH;
   localparam logic [7:0] vl_a = `TCC_OFS_VALUE_LOW;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [7:0]  i_avs_address = 8'h00;
   logic        i_avs_read = 1'b0;
   logic        i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [3:0]  i_avs_byteenable = 4'h1;
   logic [15:0] i_main_counter = 16'h0;
   logic        i_count_tick = 1'b0;
   logic        i_counter_overflow = 1'b0;
   logic        i_count_down = 1'b0;
   logic        i_center_aligned_select = 1'b0;
   logic        i_pin = 1'b0;
   wire  [31:0] o_avs_readdata;
   wire         o_avs_waitrequest;
   wire         o_pin_out;
   wire         o_pin_oe_n;
   wire         o_irq;
   int          miscompares = 0;
   int          check_count = 0;
   logic [31:0] q;
   logic [7:0]  k;

   always #5 i_clk = ~i_clk;

   tcc_channel i_tcc_channel
   (
      .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .i_main_counter(i_main_counter), .i_count_tick(i_count_tick),
      .i_counter_overflow(i_counter_overflow), .i_count_down(i_count_down),
      .i_center_aligned_select(i_center_aligned_select), .i_pin(i_pin),
      .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n), .o_irq(o_irq)
   );

   // ----------------
   // Tasks
   // ----------------
   task automatic results;
      begin
         $display("checks %0d miscompares %0d", check_count, miscompares);
         if (miscompares == 0 && check_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      begin
         check_count++;
         if (got !== exp)
         begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // No fixed latency assumed; bounded wait for waitrequest low
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      begin
         n = 0;
         i_avs_address <= a;
         i_avs_read <= !w;
         i_avs_write <= w;
         i_avs_writedata <= {24'h0, d};
         do
         begin
            @(posedge i_clk);
            n++;
         end
         while (o_avs_waitrequest !== 1'b0 && n < 40);
         if (n >= 40)
            chk(8'h01, 8'h00);
         q = o_avs_readdata;
         i_avs_read <= 1'b0;
         i_avs_write <= 1'b0;
         @(posedge i_clk);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      begin
         bus(1'b0, a, 8'h00);
         chk(q[7:0], exp);
      end
   endtask

   task automatic tick(input logic [15:0] c, input logic dn, input logic ov);
      begin
         i_main_counter <= c;
         i_count_down <= dn;
         i_counter_overflow <= ov;
         i_count_tick <= 1'b1;
         @(posedge i_clk);
         i_count_tick <= 1'b0;
         i_counter_overflow <= 1'b0;
         repeat (3) @(posedge i_clk);
      end
   endtask

   // Pin goes through a synchroniser, so allow several edges
   task automatic pin(input logic v);
      begin
         i_pin <= v;
         repeat (6) @(posedge i_clk);
      end
   endtask

   // ----------------
   // Tests
   // ----------------
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(sc_a, 8'h00);
      rd(vh_a, 8'h00);
      rd(vl_a, 8'h00);
      wr(8'h24, 8'hff);
      rd(8'h24, 8'h00);
      wr(sc_a, 8'h14);
      wr(vh_a, 8'h12);
      wr(vl_a, 8'h34);
      rd(vh_a, 8'h12);
      rd(vl_a, 8'h34);
      wr(vh_a, 8'h56);
      wr(sc_a, 8'h14);
      wr(vl_a, 8'h78);
      rd(vh_a, 8'h12);
      for (k = 8'h3; k != 8'h0; k--)
      begin
         wr(sc_a, 8'h10 | (k << 2));
         tick(16'h1234, 1'b0, 1'b0);
         chk({7'h0, o_pin_out}, {7'h0, k != 8'h2});
      end
      chk({7'h0, o_pin_oe_n}, 8'h00);
      wr(sc_a, 8'h14);
      rd(sc_a, 8'h94);
      tick(16'h1234, 1'b0, 1'b0);
      wr(sc_a, 8'h54);
      rd(sc_a, 8'hd4);
      wr(sc_a, 8'hd4);
      rd(sc_a, 8'hd4);
      wr(sc_a, 8'h54);
      rd(sc_a, 8'h54);
      tick(16'h1234, 1'b0, 1'b0);
      chk({7'h0, o_irq}, 8'h01);
      wr(sc_a, 8'h14);
      // Request register lags the enable by one edge
      @(posedge i_clk);
      chk({7'h0, o_irq}, 8'h00);
      rd(sc_a, 8'h94);
      i_center_aligned_select <= 1'b1;
      wr(sc_a, 8'h08);
      tick(16'h1234, 1'b0, 1'b0);
      chk({7'h0, o_pin_out}, 8'h00);
      rd(sc_a, 8'h88);
      wr(sc_a, 8'h08);
      tick(16'h1234, 1'b1, 1'b0);
      chk({7'h0, o_pin_out}, 8'h01);
      rd(sc_a, 8'h88);
      i_center_aligned_select <= 1'b0;
      wr(sc_a, 8'h28);
      tick(16'h0000, 1'b0, 1'b1);
      chk({7'h0, o_pin_out}, 8'h01);
      tick(16'h1234, 1'b0, 1'b0);
      chk({7'h0, o_pin_out}, 8'h00);
      wr(sc_a, 8'h24);
      tick(16'h0000, 1'b0, 1'b1);
      chk({7'h0, o_pin_out}, 8'h00);
      tick(16'h1234, 1'b0, 1'b0);
      chk({7'h0, o_pin_out}, 8'h01);
      rd(sc_a, 8'ha4);
      wr(sc_a, 8'h04);
      rd(sc_a, 8'h04);
      i_main_counter <= 16'habcd;
      pin(1'b1);
      rd(sc_a, 8'h84);
      rd(vh_a, 8'hab);
      i_main_counter <= 16'h5555;
      pin(1'b0);
      pin(1'b1);
      rd(vl_a, 8'hcd);
      rd(vh_a, 8'h55);
      i_main_counter <= 16'h7777;
      pin(1'b0);
      pin(1'b1);
      wr(sc_a, 8'h04);
      rd(vl_a, 8'h77);
      // Compare mode drives the pin first, so code 00 must release it
      wr(sc_a, 8'h14);
      @(posedge i_clk);
      chk({7'h0, o_pin_oe_n}, 8'h00);
      wr(sc_a, 8'h10);
      repeat (2) @(posedge i_clk);
      chk({7'h0, o_pin_oe_n}, 8'h01);
      results;
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge i_clk);
      miscompares++;
      results;
   end
endmodule // tcc_channel_test
